/* File: core/adc_cal_pkg.sv */
// Shared constants and types for the channel calibration block
package adc_cal_pkg;
    localparam int NUM_CH = 8;
    localparam int DATA_W = 24;
    localparam int PHASE_W = 10;
    localparam int CNT_W = 14;
    localparam int GAIN_FRAC = 23;
    localparam int PHASE_CAP = 512;
    localparam int LOG2_CAP = 10;
    localparam int MOD_DIV = 4;
    // ------------------------------------------------------------
    // Reset values and output saturation limits
    // ------------------------------------------------------------
    localparam logic [23:0] OCAL_RST = 24'h000000;
    localparam logic [23:0] GCAL_RST = 24'h800000;
    localparam logic [2:0] OSR_SEL_RST = 3'h0;
    localparam logic [23:0] OUT_MAX = 24'h7fffff;
    localparam logic [23:0] OUT_MIN = 24'h800000;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [3:0] CH_PAGE = 4'h1;
    localparam logic [2:0] CFG_IDX = 3'h0;
    localparam logic [2:0] OCH_IDX = 3'h1;
    localparam logic [2:0] OCL_IDX = 3'h2;
    localparam logic [2:0] GCH_IDX = 3'h3;
    localparam logic [2:0] GCL_IDX = 3'h4;
    localparam logic [2:0] DATA_IDX = 3'h5;
    localparam int SEL_LSB = 0;
    localparam int PHASE_LSB = 16;
    localparam int OSR_LSB = 0;
    localparam int DATA_READY_N_BIT = 8;
    // ------------------------------------------------------------
    // Shared test source
    // ------------------------------------------------------------
    localparam logic [4:0] TEST_PERIOD = 5'h1e;
    localparam logic [4:0] TEST_POS_ONES = 5'h11;
    localparam logic [4:0] TEST_NEG_ONES = 5'h0d;
    localparam logic [4:0] SHORT_ONES = 5'h0f;

    typedef enum logic [1:0] {
        SEL_NORMAL = 2'h0,
        SEL_SHORT = 2'h1,
        SEL_TEST_POS = 2'h2,
        SEL_TEST_NEG = 2'h3
    } input_sel_t;

    typedef struct packed {
        input_sel_t input_select;
        logic signed [9:0] phase_offset_field;
    } chan_cfg_t;
endpackage

/* File: core/phase_window.sv */
// One channel's shifted decimation window with phase clipping
`timescale 1ns/100ps
module phase_window (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Sample stream
    input wire logic i_tick,
    input wire logic i_bit,
    input wire logic [13:0] i_ref_cnt,
    input wire logic [3:0] i_osr_log2,
    input wire logic signed [9:0] i_phase,
    // Window result
    output logic o_valid,
    output logic signed [23:0] o_result
);
    logic [14:0] osr;
    logic signed [14:0] lim;
    logic signed [14:0] ph_ext;
    logic signed [14:0] eff;
    logic [13:0] pos;
    logic last;
    logic [14:0] ones_r;
    logic [14:0] ones_tot;
    logic signed [16:0] val;
    logic signed [39:0] scaled;
    logic [14:0] n_r;
    logic started_r;

    assign osr = 15'(1) << i_osr_log2;
    assign lim = (i_osr_log2 >= 4'(adc_cal_pkg::LOG2_CAP)) ?
        15'(adc_cal_pkg::PHASE_CAP) : $signed(osr >> 1);
    assign ph_ext = 15'(i_phase);
    assign eff = (ph_ext > lim - 15'sd1) ? lim - 15'sd1 :
        (ph_ext < -lim) ? -lim : ph_ext;
    assign pos = 14'(i_ref_cnt - 14'(eff)) & 14'(osr - 15'd1);
    assign last = (pos == 14'(osr - 15'd1));
    assign ones_tot = ones_r + 15'(i_bit);
    assign val = $signed({1'b0, ones_tot, 1'b0}) - $signed({2'b00, osr});
    assign scaled = 40'(val) <<< (5'd23 - 5'(i_osr_log2));

    always_ff @(posedge clk) begin
        if (rst) begin
            ones_r <= '0;
            o_valid <= 1'b0;
            o_result <= '0;
        end else begin
            o_valid <= i_tick & last;
            if (i_tick) begin
                ones_r <= last ? '0 : ones_tot;
            end
            if (i_tick & last) begin
                o_result <= (scaled > 40'sh7fffff) ? adc_cal_pkg::OUT_MAX : scaled[23:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst || $changed(i_phase) || $changed(i_osr_log2)) begin
            n_r <= '0;
            started_r <= 1'b0;
        end else if (i_tick) begin
            n_r <= last ? '0 : n_r + 15'd1;
            started_r <= started_r | last;
        end
    end

    clip_range_a: assert property (@(posedge clk) disable iff (rst)
        eff <= lim - 15'sd1 && eff >= -lim) else $error("phase not clipped");
    window_len_a: assert property (@(posedge clk) disable iff (rst)
        (i_tick && last && started_r && !$changed(i_phase) && !$changed(i_osr_log2))
        |-> (n_r + 15'd1 == osr))
        else $error("window length differs from osr");
    end_point_a: assert property (@(posedge clk) disable iff (rst)
        (i_tick && last) |-> ##1 o_valid) else $error("window end lost");
endmodule // phase_window

/* File: core/cal_correct.sv */
// Offset subtraction then gain multiply with rounding and saturation
`timescale 1ns/100ps
module cal_correct (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Raw conversion and coefficients
    input wire logic i_valid,
    input wire logic signed [23:0] i_data,
    input wire logic [23:0] i_ocal,
    input wire logic [23:0] i_gcal,
    // Corrected conversion
    output logic o_valid,
    output logic signed [23:0] o_data
);
    logic signed [24:0] diff;
    logic signed [49:0] prod;
    logic signed [49:0] rnd;
    logic signed [26:0] shr;
    logic signed [23:0] sat;

    assign diff = 25'(i_data) - 25'($signed(i_ocal));
    assign prod = diff * $signed({1'b0, i_gcal});
    assign rnd = prod + (50'sd1 <<< (adc_cal_pkg::GAIN_FRAC - 1));
    assign shr = 27'(rnd >>> adc_cal_pkg::GAIN_FRAC);
    assign sat = (shr > 27'sh7fffff) ? adc_cal_pkg::OUT_MAX :
        (shr < -27'sh800000) ? adc_cal_pkg::OUT_MIN : shr[23:0];

    always_ff @(posedge clk) begin
        if (rst) begin
            o_valid <= 1'b0;
            o_data <= '0;
        end else begin
            o_valid <= i_valid;
            if (i_valid) begin
                o_data <= sat;
            end
        end
    end

    unity_pass_a: assert property (@(posedge clk) disable iff (rst)
        (i_valid && i_gcal == 24'h800000 && i_ocal == 24'h000000) |=> o_data == $past(i_data))
        else $error("unity correction altered data");
    offset_sub_a: assert property (@(posedge clk) disable iff (rst)
        (i_valid && i_gcal == 24'h800000 && diff < 25'sh7fffff && diff > -25'sh800000)
        |=> o_data == $past(i_data) - $past($signed(i_ocal)))
        else $error("offset not subtracted");
endmodule // cal_correct

/* File: core/adc_channel_calibration.sv */
// Eight-channel phase window, test select and offset/gain correction core
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/100ps
module adc_channel_calibration #(
    parameter int NCH = adc_cal_pkg::NUM_CH,
    parameter int DIV = adc_cal_pkg::MOD_DIV
) (
    // Clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_SYS_RST,
    // Modulator bitstreams, same clock domain
    input wire logic [7:0] i_MOD_BITS,
    // APB slave
    input wire logic i_PSEL,
    input wire logic i_PENABLE,
    input wire logic i_PWRITE,
    input wire logic [11:0] i_PADDR,
    input wire logic [31:0] i_PWDATA,
    output logic [31:0] o_PRDATA,
    output logic o_PREADY,
    output logic o_PSLVERR,
    // Data ready, active low
    output logic o_DATA_READY_N
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    adc_cal_pkg::chan_cfg_t cfg_r [NCH];
    logic [23:0] ocal_r [NCH];
    logic [23:0] gcal_r [NCH];
    logic signed [23:0] result_r [NCH];
    logic [2:0] osr_sel_r;
    logic [NCH-1:0] done_r;
    logic [7:0] div_r;
    logic tick_r;
    logic [13:0] ref_r;
    logic [4:0] test_r;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic setup;
    logic wr_go;
    logic ch_page;
    logic [2:0] ch_sel;
    logic [2:0] reg_sel;
    logic is_ctrl;
    logic is_status;
    logic ch_hit;
    logic mapped;
    logic [31:0] rd_mux;
    logic [3:0] osr_log2;
    logic [13:0] osr_mask;

    assign setup = i_PSEL & ~i_PENABLE;
    assign wr_go = i_PSEL & i_PENABLE & o_PREADY & i_PWRITE;
    assign ch_page = i_PADDR[11:8] == adc_cal_pkg::CH_PAGE;
    assign ch_sel = i_PADDR[7:5];
    assign reg_sel = i_PADDR[4:2];
    assign is_ctrl = i_PADDR == adc_cal_pkg::CTRL_OFS;
    assign is_status = i_PADDR == adc_cal_pkg::STATUS_OFS;
    assign ch_hit = ch_page && i_PADDR[1:0] == 2'h0 && reg_sel <= adc_cal_pkg::DATA_IDX &&
        32'(ch_sel) < NCH;
    assign mapped = is_ctrl | is_status | ch_hit;
    assign osr_log2 = 4'd7 + 4'(osr_sel_r);
    assign osr_mask = 14'((15'd1 << osr_log2) - 15'd1);

    always_comb begin
        rd_mux = 32'h00000000;
        if (is_ctrl) begin
            rd_mux[adc_cal_pkg::OSR_LSB +: 3] = osr_sel_r;
        end else if (is_status) begin
            rd_mux[NCH-1:0] = done_r;
            rd_mux[adc_cal_pkg::DATA_READY_N_BIT] = o_DATA_READY_N;
        end else if (ch_hit) begin
            unique case (reg_sel)
                adc_cal_pkg::CFG_IDX: begin
                    rd_mux[adc_cal_pkg::SEL_LSB +: 2] = cfg_r[ch_sel].input_select;
                    rd_mux[adc_cal_pkg::PHASE_LSB +: 10] = cfg_r[ch_sel].phase_offset_field;
                end
                adc_cal_pkg::OCH_IDX: rd_mux[15:0] = ocal_r[ch_sel][23:8];
                adc_cal_pkg::OCL_IDX: rd_mux[7:0] = ocal_r[ch_sel][7:0];
                adc_cal_pkg::GCH_IDX: rd_mux[15:0] = gcal_r[ch_sel][23:8];
                adc_cal_pkg::GCL_IDX: rd_mux[7:0] = gcal_r[ch_sel][7:0];
                default: rd_mux[23:0] = result_r[ch_sel];
            endcase
        end
    end

    // ------------------------------------------------------------
    // APB answer: one access cycle, no wait
    // ------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            o_PRDATA <= 32'h00000000;
            o_PREADY <= 1'b0;
            o_PSLVERR <= 1'b0;
        end else begin
            o_PREADY <= setup;
            if (setup) begin
                o_PRDATA <= i_PWRITE ? 32'h00000000 : rd_mux;
                o_PSLVERR <= ~mapped;
            end
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            osr_sel_r <= adc_cal_pkg::OSR_SEL_RST;
        end else if (wr_go && is_ctrl) begin
            osr_sel_r <= i_PWDATA[adc_cal_pkg::OSR_LSB +: 3];
        end
    end

    // ------------------------------------------------------------
    // Modulator rate divider, reference counter, shared test source
    // ------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            div_r <= 8'h00;
            tick_r <= 1'b0;
            ref_r <= 14'h0000;
            test_r <= 5'h00;
        end else begin
            tick_r <= div_r == 8'(DIV - 1);
            div_r <= (div_r == 8'(DIV - 1)) ? 8'h00 : div_r + 8'h01;
            if (tick_r) begin
                ref_r <= (ref_r + 14'h0001) & osr_mask;
                test_r <= (test_r == adc_cal_pkg::TEST_PERIOD - 5'h01) ? 5'h00 : test_r + 5'h01;
            end
        end
    end

    logic test_pos;
    logic test_neg;
    logic short_bit;
    assign test_pos = test_r < adc_cal_pkg::TEST_POS_ONES;
    assign test_neg = test_r < adc_cal_pkg::TEST_NEG_ONES;
    assign short_bit = test_r < adc_cal_pkg::SHORT_ONES;

    // ------------------------------------------------------------
    // Per-channel datapath
    // ------------------------------------------------------------
    logic [NCH-1:0] mux_bit;
    logic [NCH-1:0] win_valid;
    logic [NCH-1:0] cor_valid;
    logic signed [23:0] win_data [NCH];
    logic signed [23:0] cor_data [NCH];

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            logic cfg_we;
            logic och_we;
            logic ocl_we;
            logic gch_we;
            logic gcl_we;
            assign cfg_we = wr_go && ch_hit && ch_sel == 3'(g) && reg_sel == adc_cal_pkg::CFG_IDX;
            assign och_we = wr_go && ch_hit && ch_sel == 3'(g) && reg_sel == adc_cal_pkg::OCH_IDX;
            assign ocl_we = wr_go && ch_hit && ch_sel == 3'(g) && reg_sel == adc_cal_pkg::OCL_IDX;
            assign gch_we = wr_go && ch_hit && ch_sel == 3'(g) && reg_sel == adc_cal_pkg::GCH_IDX;
            assign gcl_we = wr_go && ch_hit && ch_sel == 3'(g) && reg_sel == adc_cal_pkg::GCL_IDX;

            always_ff @(posedge I_CORE_CLK) begin
                if (I_SYS_RST) begin
                    cfg_r[g] <= '{adc_cal_pkg::SEL_NORMAL, 10'sh000};
                    ocal_r[g] <= adc_cal_pkg::OCAL_RST;
                    gcal_r[g] <= adc_cal_pkg::GCAL_RST;
                end else begin
                    if (cfg_we) begin
                        cfg_r[g].input_select <=
                            adc_cal_pkg::input_sel_t'(i_PWDATA[adc_cal_pkg::SEL_LSB +: 2]);
                        cfg_r[g].phase_offset_field <= i_PWDATA[adc_cal_pkg::PHASE_LSB +: 10];
                    end
                    if (och_we) ocal_r[g][23:8] <= i_PWDATA[15:0];
                    if (ocl_we) ocal_r[g][7:0] <= i_PWDATA[7:0];
                    if (gch_we) gcal_r[g][23:8] <= i_PWDATA[15:0];
                    if (gcl_we) gcal_r[g][7:0] <= i_PWDATA[7:0];
                end
            end

            // Test codes bypass the pin stream; all channels share one source
            assign mux_bit[g] = (cfg_r[g].input_select == adc_cal_pkg::SEL_TEST_POS) ? test_pos :
                (cfg_r[g].input_select == adc_cal_pkg::SEL_TEST_NEG) ? test_neg :
                (cfg_r[g].input_select == adc_cal_pkg::SEL_SHORT) ? short_bit :
                i_MOD_BITS[g];

            phase_window u_win (
                .clk(I_CORE_CLK),
                .rst(I_SYS_RST),
                .i_tick(tick_r),
                .i_bit(mux_bit[g]),
                .i_ref_cnt(ref_r),
                .i_osr_log2(osr_log2),
                .i_phase(cfg_r[g].phase_offset_field),
                .o_valid(win_valid[g]),
                .o_result(win_data[g])
            );

            cal_correct u_cor (
                .clk(I_CORE_CLK),
                .rst(I_SYS_RST),
                .i_valid(win_valid[g]),
                .i_data(win_data[g]),
                .i_ocal(ocal_r[g]),
                .i_gcal(gcal_r[g]),
                .o_valid(cor_valid[g]),
                .o_data(cor_data[g])
            );

            always_ff @(posedge I_CORE_CLK) begin
                if (I_SYS_RST) begin
                    result_r[g] <= 24'h000000;
                end else if (cor_valid[g]) begin
                    result_r[g] <= cor_data[g];
                end
            end

            pos_test_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
                cfg_r[g].input_select == adc_cal_pkg::SEL_TEST_POS |-> mux_bit[g] == test_pos)
                else $error("test source not routed");
        end
    endgenerate

    // ------------------------------------------------------------
    // Data ready: falls once every shifted window has closed
    // ------------------------------------------------------------
    logic all_done;
    assign all_done = &done_r;

    // Fall comes one cycle after the last window so aligned channels still pulse high
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) begin
            done_r <= '0;
            o_DATA_READY_N <= 1'b1;
        end else if (all_done) begin
            done_r <= cor_valid;
            o_DATA_READY_N <= 1'b0;
        end else begin
            done_r <= done_r | cor_valid;
            if (|cor_valid) o_DATA_READY_N <= 1'b1;
        end
    end

    data_ready_n_cause_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
        $fell(o_DATA_READY_N) |-> $past(all_done)) else $error("ready without all windows");
    reset_coef_a: assert property (@(posedge I_CORE_CLK)
        $past(I_SYS_RST) |-> gcal_r[0] == 24'h800000 && ocal_r[0] == 24'h000000)
        else $error("coefficient reset value wrong");
    limit_128_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
        (osr_sel_r == 3'h0 && cfg_r[0].phase_offset_field == 10'sd100)
        |-> g_ch[0].u_win.eff == 15'sd63) else $error("phase 100 not clipped to 63");
    apb_ready_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
        (i_PSEL && !i_PENABLE) |=> o_PREADY ##1 !o_PREADY) else $error("apb answer timing");
endmodule // adc_channel_calibration

/* File: tb/mod_source.sv */
// Modulator bitstream source standing in for the analog front end
`timescale 1ns/100ps
module mod_source #(
    parameter int DIV = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Per-channel pattern: 0 low, 1 high, 2 or 3 toggling each sample
    input wire logic [15:0] i_mode,
    // Bitstreams
    output logic [7:0] o_bits
);
    // ------------------------------------------------------------
    // Toggle source
    // ------------------------------------------------------------
    // Toggling once per sample period gives exactly half ones in any window
    int div_cnt;
    logic alt_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            div_cnt <= 0;
            alt_r <= 1'b0;
        end else if (div_cnt == DIV - 1) begin
            div_cnt <= 0;
            alt_r <= ~alt_r;
        end else begin
            div_cnt <= div_cnt + 1;
        end
    end
    always_comb begin
        for (int g = 0; g < 8; g++) begin
            o_bits[g] = i_mode[2 * g + 1] ? alt_r : i_mode[2 * g];
        end
    end
endmodule // mod_source

/* File: tb/tb_adc_channel_calibration.sv */
// Self-checking bench for the channel calibration core
`timescale 1ns/100ps
module tb_adc_channel_calibration;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ready_n;
    logic [7:0] mod_bits;
    // Ch5 high, ch6 low, the rest toggling
    logic [15:0] mode = 16'h86aa;
    int fail_count = 0;
    int checks_done = 0;
    logic [31:0] rd;
    logic err;

    initial begin
        forever #2 clk = ~clk;
    end

    mod_source #(.DIV(4)) src (.clk(clk), .rst(rst), .i_mode(mode), .o_bits(mod_bits));
    adc_channel_calibration #(.NCH(8), .DIV(4)) dut (.I_CORE_CLK(clk), .I_SYS_RST(rst),
        .i_MOD_BITS(mod_bits), .i_PSEL(psel), .i_PENABLE(penable), .i_PWRITE(pwrite),
        .i_PADDR(paddr), .i_PWDATA(pwdata), .o_PRDATA(prdata), .o_PREADY(pready),
        .o_PSLVERR(pslverr), .o_DATA_READY_N(ready_n));

    // ------------------------------------------------------------
    // Common tasks
    // ------------------------------------------------------------
    task automatic final_report();
        if (fail_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chk(32'h0, 32'h1);
            final_report();
        end
    endtask

    function automatic logic [11:0] ca(input int g, input logic [2:0] idx);
        return {adc_cal_pkg::CH_PAGE, 3'(g), idx, 2'b00};
    endfunction

    task automatic setc(input int g, input logic [2:0] idx, input logic [23:0] v);
        apb(1'b1, ca(g, idx), {16'h0, v[23:8]});
        apb(1'b1, ca(g, idx + 3'h1), {24'h0, v[7:0]});
    endtask

    task automatic getc(input int g, input logic [2:0] idx, output logic [23:0] v);
        apb(1'b0, ca(g, idx), 32'h0);
        v[23:8] = rd[15:0];
        apb(1'b0, ca(g, idx + 3'h1), 32'h0);
        v[7:0] = rd[7:0];
    endtask

    // Waits for k falling edges of data ready, each under a bound
    task automatic wait_falls(input int k);
        int n;
        logic prev;
        for (int i = 0; i < k; i++) begin
            n = 0;
            do begin
                prev = ready_n;
                @(posedge clk);
                n++;
            end while (!(prev === 1'b1 && ready_n === 1'b0) && n < 20000);
            if (n >= 20000) begin
                chk(32'h0, 32'h1);
                final_report();
            end
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [23:0] v;
        chk({31'h0, ready_n}, 32'h1);
        for (int g = 0; g < 8; g++) begin
            getc(g, adc_cal_pkg::OCH_IDX, v);
            chk({8'h0, v}, 32'h000000);
            getc(g, adc_cal_pkg::GCH_IDX, v);
            chk({8'h0, v}, 32'h800000);
        end
        // Unmapped place is refused both ways
        apb(1'b0, 12'h0fc, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, 12'h0fc, 32'h1234);
        chk({31'h0, err}, 32'h1);
    endtask

    task automatic t_coefs();
        logic [23:0] v;
        for (int g = 0; g < 8; g++) begin
            setc(g, adc_cal_pkg::OCH_IDX, {8'(g + 1), 16'h5a3c});
            setc(g, adc_cal_pkg::GCH_IDX, {8'(g + 9), 16'hc3a5});
        end
        for (int g = 0; g < 8; g++) begin
            getc(g, adc_cal_pkg::OCH_IDX, v);
            chk({8'h0, v}, {8'h0, 8'(g + 1), 16'h5a3c});
            getc(g, adc_cal_pkg::GCH_IDX, v);
            chk({8'h0, v}, {8'h0, 8'(g + 9), 16'hc3a5});
        end
    endtask

    // Mid-run reset wipes coefficients; host then writes a new ch3 offset and reads it back
    task automatic t_rerun();
        logic [23:0] v;
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        getc(3, adc_cal_pkg::OCH_IDX, v);
        chk({8'h0, v}, 32'h000000);
        getc(3, adc_cal_pkg::GCH_IDX, v);
        chk({8'h0, v}, 32'h800000);
        setc(3, adc_cal_pkg::OCH_IDX, 24'h000010);
        getc(3, adc_cal_pkg::OCH_IDX, v);
        chk({8'h0, v}, 32'h000010);
    endtask

    task automatic t_correct();
        int ch [6] = '{1, 0, 5, 6, 4, 7};
        logic [23:0] ofs [6] = '{24'h000100, 24'h000001, 24'h0, 24'h0, 24'h7fffff, 24'h0};
        logic [23:0] gn [6] = '{24'h400000, 24'h400000, 24'hffffff, 24'hffffff, 24'h1, 24'h800000};
        logic [23:0] ex [6] = '{24'hffff80, 24'h0, 24'h7fffff, 24'h800000, 24'hffffff, 24'h0};
        for (int i = 0; i < 6; i++) begin
            setc(ch[i], adc_cal_pkg::OCH_IDX, ofs[i]);
            setc(ch[i], adc_cal_pkg::GCH_IDX, gn[i]);
        end
        wait_falls(2);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ca(ch[i], adc_cal_pkg::DATA_IDX), 32'h0);
            chk(rd, {8'h0, ex[i]});
        end
    endtask

    task automatic t_select();
        logic [31:0] pos;
        logic signed [23:0] sv;
        apb(1'b1, ca(6, adc_cal_pkg::CFG_IDX), 32'h1);
        apb(1'b1, ca(2, adc_cal_pkg::CFG_IDX), 32'h2);
        apb(1'b1, ca(3, adc_cal_pkg::CFG_IDX), 32'h3);
        apb(1'b1, ca(7, adc_cal_pkg::CFG_IDX), 32'h2);
        wait_falls(2);
        apb(1'b0, ca(2, adc_cal_pkg::DATA_IDX), 32'h0);
        pos = rd;
        chk({31'h0, pos[23] == 1'b0 && pos[22:0] != 23'h0}, 32'h1);
        apb(1'b0, ca(3, adc_cal_pkg::DATA_IDX), 32'h0);
        chk({31'h0, rd[23]}, 32'h1);
        apb(1'b0, ca(7, adc_cal_pkg::DATA_IDX), 32'h0);
        chk(rd, pos);
        // Shorted input sits near zero even though ch6 pins are held low
        apb(1'b0, ca(6, adc_cal_pkg::DATA_IDX), 32'h0);
        sv = rd[23:0];
        chk({31'h0, sv >= -24'sh100000 && sv <= 24'sh100000}, 32'h1);
    endtask

    // Ready fall moves with the clipped phase programmed into every channel
    task automatic t_phase(input logic [2:0] sel, input logic [9:0] p, input int ticks);
        longint t0;
        longint per;
        per = longint'(128 << sel) * 16;
        apb(1'b1, adc_cal_pkg::CTRL_OFS, {29'h0, sel});
        apb(1'b0, adc_cal_pkg::CTRL_OFS, 32'h0);
        chk(rd, {29'h0, sel});
        for (int g = 0; g < 8; g++) begin
            apb(1'b1, ca(g, adc_cal_pkg::CFG_IDX), 32'h0);
        end
        wait_falls(3);
        t0 = $time;
        for (int g = 0; g < 8; g++) begin
            apb(1'b1, ca(g, adc_cal_pkg::CFG_IDX), {6'h0, p, 16'h0});
        end
        wait_falls(3);
        chk(32'(($time - t0) % per), 32'(ticks * 16));
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_coefs();
        t_rerun();
        t_correct();
        t_select();
        t_phase(3'h0, 10'd30, 30);
        t_phase(3'h0, 10'd100, 63);
        t_phase(3'h0, -10'sd100, 64);
        t_phase(3'h0, -10'sd20, 108);
        t_phase(3'h1, 10'd200, 127);
        t_phase(3'h1, 10'h200, 128);
        t_phase(3'h2, 10'd300, 255);
        final_report();
    end
endmodule // tb_adc_channel_calibration
